/* File: sim/asr_remote.sv */
/* remote serial node: sends frames on the receive line, captures frames
   from the transmit line. assumes 16 clocks a bit and 8-bit words. */
`timescale 1ns/1ps
module asr_remote #(
   parameter int BIT = 16
) (
   // clock
   input wire logic i_mclk,
   // serial line
   input wire logic i_txd,
   output logic o_rxd
);
   logic [7:0] rxq[$];
   logic [7:0] sh;
   initial o_rxd = 1'b1;
   // start, data lsb first, stop; a bad stop is low for its first 10 clocks, over its sample point
   task automatic send(input logic [7:0] d, input logic bad_stop);
      logic [8:0] f;
      f = {d, 1'b0};
      for (int i = 0; i < 9; i++) begin
         o_rxd <= f[i];
         repeat (BIT) @(posedge i_mclk);
      end
      o_rxd <= ~bad_stop;
      repeat (10) @(posedge i_mclk);
      o_rxd <= 1'b1;
      repeat (BIT - 10) @(posedge i_mclk);
   endtask
   // mid-bit sampling from the start edge; frames with a bad stop are dropped
   initial begin
      forever begin
         @(negedge i_txd);
         repeat (BIT / 2) @(posedge i_mclk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge i_mclk);
            sh = {i_txd, sh[7:1]};
         end
         repeat (BIT) @(posedge i_mclk);
         if (i_txd) rxq.push_back(sh);
      end
   end
endmodule

/* File: sim/asr_uart_chk.sv */
/* port checker for the serial transceiver.
   assumes a bind onto asr_uart; run-length bounds hold for tx code 0. */
`timescale 1ns/1ps
`include "asr_defines.svh"
module asr_uart_chk #(
   parameter int DATA_W = 8
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // register port
   input wire asr_pkg::asr_bus_s i_bus,
   input wire logic [DATA_W-1:0] o_rdata,
   // serial line and interrupt
   input wire logic i_rxd,
   input wire logic o_txd,
   input wire logic o_txd_oe,
   input wire logic o_irq
);
   import asr_pkg::*;
   logic [7:0] ctrl1;
   logic [7:0] ctrl2;
   logic [7:0] baud;
   logic te_seen;
   logic re_seen;
   logic [8:0] low_cnt;
   logic quiet;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // shadow of what software wrote; hardware-cleared bits are not tracked
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl1 <= 8'h00;
         ctrl2 <= 8'h00;
         baud <= 8'h00;
         te_seen <= 1'b0;
         re_seen <= 1'b0;
      end else if (i_bus.wr) begin
         if (i_bus.addr == `ASR_OFF_CTRL1) ctrl1 <= i_bus.wdata;
         if (i_bus.addr == `ASR_OFF_BAUD) baud <= i_bus.wdata;
         if (i_bus.addr == `ASR_OFF_CTRL2) begin
            ctrl2 <= i_bus.wdata;
            te_seen <= te_seen | i_bus.wdata[3];
            re_seen <= re_seen | i_bus.wdata[2];
         end
      end
   end
   // length of the current low run on the tx line, saturating
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_cnt <= 9'h000;
      end else if (o_txd) begin
         low_cnt <= 9'h000;
      end else if (low_cnt != 9'h1ff) begin
         low_cnt <= low_cnt + 9'h001;
      end
   end
   assign quiet = (ctrl2[7:4] == 4'h0) && !ctrl1[0];

   never_en_a: assert property (!te_seen |-> o_txd && !o_txd_oe)
      else $error("tx pin driven before tx enable");
   oe_rise_a: assert property ($rose(o_txd_oe) |-> ctrl2[3] || (te_seen && ctrl2[2]))
      else $error("tx pin taken without tx enable");
   oe_fall_a: assert property ($fell(o_txd_oe) |-> (!ctrl2[3] && !ctrl2[2]) || ctrl1[5])
      else $error("tx pin released while an enable is set");
   te_delay_a: assert property ($rose(ctrl2[3]) |-> o_txd [*8])
      else $error("frame started inside first bit time");
   fall_hold_a: assert property ($fell(o_txd) |-> !o_txd [*8])
      else $error("low bit shorter than a bit time");
   rise_hold_a: assert property ($rose(o_txd) |-> o_txd [*8])
      else $error("high bit shorter than a bit time");
   low_run_a: assert property (baud[7:3] == 5'h00 |-> low_cnt <= 9'h0b0)
      else $error("low run longer than a frame");
   irq_quiet_a: assert property (quiet && $past(quiet) |-> !o_irq)
      else $error("interrupt with every enable clear");
   rx_quiet_a: assert property (!re_seen && i_bus.rd && i_bus.addr == `ASR_OFF_STATUS
      |=> o_rdata[5:0] == 6'h00)
      else $error("receive flag set with receiver never enabled");

   // main scenarios reached
   cover property ($fell(o_txd));
   cover property ($rose(o_irq));
   cover property ($rose(o_txd_oe));
endmodule

/* File: sim/asr_uart_tb_top.sv */
/* self-checking bench for the serial transceiver: register tasks, a
   remote node and a byte-queue model. assumes checker and node compiled. */
`timescale 1ns/1ps
`include "asr_defines.svh"
module asr_uart_tb_top;
   import asr_pkg::*;
   localparam logic [2:0] RA [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
   localparam logic [7:0] RV [5] = '{8'hc0, 8'h00, 8'h00, 8'h00, 8'h00};
   logic i_mclk;
   logic i_rst_n;
   asr_bus_s bus;
   logic [7:0] o_rdata;
   logic i_rxd;
   logic o_txd;
   logic o_txd_oe;
   logic o_irq;
   int errors;
   int n_checks;
   logic [31:0] seed;
   logic [7:0] exp_q[$];
   logic [7:0] v;
   logic [7:0] b;
   logic pe;

   asr_uart #(.DATA_W(8)) u_asr_uart (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus(bus),
      .o_rdata(o_rdata), .i_rxd(i_rxd), .o_txd(o_txd), .o_txd_oe(o_txd_oe), .o_irq(o_irq));
   asr_remote u_asr_remote (.i_mclk(i_mclk), .i_txd(o_txd), .o_rxd(i_rxd));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic complete_run();
      if (errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask
   // irq is registered an edge after its cause; look once that edge has settled
   task automatic chk_irq(input logic e);
      @(negedge i_mclk);
      chk("irq", {7'h00, e}, {7'h00, o_irq});
      @(posedge i_mclk);
   endtask
   // one-cycle strobes, released after the taking edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge i_mclk);
      bus.wr <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge i_mclk);
      bus.rd <= 1'b0;
      #1 d = o_rdata;
      @(posedge i_mclk);
   endtask
   // idle flag masked: its timing depends on line history, not on the case
   task automatic st(input logic [7:0] e);
      rd(`ASR_OFF_STATUS, v);
      chk("status", e, v & 8'hef);
   endtask
   task automatic poll(input int bitn);
      for (int i = 0; i < 500; i++) begin
         rd(`ASR_OFF_STATUS, v);
         if (v[bitn] === 1'b1) return;
      end
      errors++;
      complete_run();
   endtask
   task automatic next_byte();
      seed = lfsr(seed);
      b = seed[7:0];
   endtask

   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   initial begin
      i_rst_n = 1'b0;
      bus = '0;
      errors = 0;
      n_checks = 0;
      seed = 32'h370a684c;
      repeat (6) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      // reset values; status and unmapped writes must be ignored
      wr(`ASR_OFF_STATUS, 8'h00);
      wr(3'h5, 8'hff);
      foreach (RA[i]) begin
         rd(RA[i], v);
         chk("reset", RV[i], v);
      end
      chk("oe", 8'h00, {7'h00, o_txd_oe});
      wr(`ASR_OFF_CTRL1, 8'hff);
      rd(`ASR_OFF_CTRL1, v);
      chk("ctrl1", 8'h7f, v);
      wr(`ASR_OFF_CTRL1, 8'h00);
      // transmit: empty interrupt, then three words back to back
      wr(`ASR_OFF_BAUD, 8'h00);
      wr(`ASR_OFF_CTRL2, 8'h88);
      chk_irq(1'b1);
      wr(`ASR_OFF_CTRL2, 8'h08);
      chk_irq(1'b0);
      repeat (20) @(posedge i_mclk);
      for (int i = 0; i < 3; i++) begin
         next_byte();
         poll(7);
         wr(`ASR_OFF_DATA, b);
         exp_q.push_back(b);
      end
      for (int i = 0; i < 4000 && u_asr_remote.rxq.size() < 3; i++) @(posedge i_mclk);
      if (u_asr_remote.rxq.size() < 3) begin
         errors++;
         complete_run();
      end
      while (exp_q.size() > 0) chk("txbyte", exp_q.pop_front(), u_asr_remote.rxq.pop_front());
      repeat (16) @(posedge i_mclk);
      st(8'hc0);
      chk("oe", 8'h01, {7'h00, o_txd_oe});
      // receive with interrupt, then clear sequence
      wr(`ASR_OFF_CTRL2, 8'h2c);
      next_byte();
      u_asr_remote.send(b, 1'b0);
      chk_irq(1'b1);
      st(8'he0);
      rd(`ASR_OFF_DATA, v);
      chk("rxbyte", b, v);
      st(8'hc0);
      chk_irq(1'b0);
      // overrun keeps the first word
      next_byte();
      exp_q.push_back(b);
      u_asr_remote.send(b, 1'b0);
      next_byte();
      u_asr_remote.send(b, 1'b0);
      st(8'he8);
      rd(`ASR_OFF_DATA, v);
      chk("rxbyte", exp_q.pop_front(), v);
      st(8'hc0);
      // stop bit low: framing error, word still handed over
      next_byte();
      u_asr_remote.send(b, 1'b1);
      st(8'he2);
      rd(`ASR_OFF_DATA, v);
      chk("rxbyte", b, v);
      // parity check, even and odd, with its own interrupt only
      wr(`ASR_OFF_CTRL2, 8'h0c);
      for (int i = 0; i < 4; i++) begin
         wr(`ASR_OFF_CTRL1, 8'h05 | {6'h00, i[0], 1'b0});
         next_byte();
         pe = (^b) ^ i[0];
         u_asr_remote.send(b, 1'b0);
         chk_irq(pe);
         st(8'he0 | {7'h00, pe});
         rd(`ASR_OFF_DATA, v);
      end
      // muted: plain word ignored, address mark wakes and lands
      wr(`ASR_OFF_CTRL1, 8'h08);
      wr(`ASR_OFF_CTRL2, 8'h2e);
      u_asr_remote.send(8'h15, 1'b0);
      st(8'hc0);
      u_asr_remote.send(8'h95, 1'b0);
      st(8'he0);
      rd(`ASR_OFF_CTRL2, v);
      chk("ctrl2", 8'h2c, v);
      rd(`ASR_OFF_DATA, v);
      chk("rxbyte", 8'h95, v);
      // ten quiet bit times after a landed word raise the idle flag
      repeat (200) @(posedge i_mclk);
      rd(`ASR_OFF_STATUS, v);
      chk("idle", 8'hd0, v);
      // both enables clear: pin released after the line settles
      wr(`ASR_OFF_CTRL2, 8'h00);
      repeat (200) @(posedge i_mclk);
      chk("oe", 8'h00, {7'h00, o_txd_oe});
      complete_run();
   end
endmodule

bind asr_uart asr_uart_chk #(.DATA_W(DATA_W)) u_asr_uart_chk (.i_mclk(i_mclk),
   .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata), .i_rxd(i_rxd), .o_txd(o_txd),
   .o_txd_oe(o_txd_oe), .o_irq(o_irq));

/* File: src/asr_defines.svh */
/*
 * register offsets, field positions, reset values and timing counts for the
 * asynchronous serial transceiver. assumes inclusion by bare name.
 */
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH
`define ASR_OFF_STATUS 3'h0
`define ASR_OFF_DATA 3'h1
`define ASR_OFF_BAUD 3'h2
`define ASR_OFF_CTRL1 3'h3
`define ASR_OFF_CTRL2 3'h4
`define ASR_RST_STATUS 8'hc0
`define ASR_RST_CTRL1 8'h00
`define ASR_RST_CTRL2 8'h00
`define ASR_RST_BAUD 8'h00
`define ASR_OVERSAMPLE 8'h10
`define ASR_B_TIE 7
`define ASR_B_TX_DONE_IRQ_ENABLE 6
`define ASR_B_RIE 5
`define ASR_B_IDLE_IRQ_ENABLE 4
`define ASR_B_TE 3
`define ASR_B_RE 2
`define ASR_B_RWU 1
`define ASR_B_SBK 0
`define ASR_B_R8 7
`define ASR_B_T8 6
`define ASR_B_LPD 5
`define ASR_B_M 4
`define ASR_B_WAKE 3
`define ASR_B_PCE 2
`define ASR_B_PS 1
`define ASR_B_PIE 0
`endif

/* File: src/asr_pkg.sv */
/*
 * types shared by the serial transceiver. assumes nothing of its surroundings.
 */
package asr_pkg;
   typedef struct packed {
      logic tx_buf_empty;
      logic tx_complete;
      logic rx_data_ready;
      logic idle;
      logic overrun;
      logic noise_flag;
      logic framing_error_flag;
      logic parity_error_flag;
   } asr_status_s;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } asr_bus_s;
   typedef enum logic [3:0] {
      ASR_TX_IDLE = 4'b0001,
      ASR_TX_WAIT = 4'b0010,
      ASR_TX_SHIFT = 4'b0100,
      ASR_TX_DONE = 4'b1000
   } asr_tx_e;
   typedef enum logic [2:0] {
      ASR_RX_HUNT = 3'b001,
      ASR_RX_SHIFT = 3'b010,
      ASR_RX_STOP = 3'b100
   } asr_rx_e;
endpackage

/* File: src/asr_uart.sv */
/*
 * asynchronous serial transceiver: status/control/data/baud registers, baud
 * generation, transmitter and receiver with parity, mute and wake-up.
 * assumes a single-cycle register port and a receive line already
 * synchronous to i_mclk.
 */
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "asr_defines.svh"
// Operation
// - tx empty set on buffer-to-shifter move; cleared by status then data write
// - buffer never moves to shifter while tx empty flag is still set
// - tx complete set after data frame only; cleared by status then data write
// - rx ready set when received word lands; cleared by status then data read
// - idle flag set on idle line, rearmed only after rx ready sets again
// - overrun when word completes with rx ready set; buffer kept
// - noise flag set on noisy frame, no interrupt of its own
// - framing error on bad stop or break; overrun suppresses it
// - parity error on failed check, interrupts when parity interrupt enable set
// - word length bit selects 8 or 9 data bits, one start, one stop
// - ninth bits stored in and sent from control register fields
// - low-power disable stops receiver at once, data and break frames after current byte, not preambles; tx pin released when idle; dividers keep running
// - wake bit selects idle line or address mark wake-up
// - parity replaces word msb when enabled, taking effect after current byte
// - parity select: 0 even, 1 odd, latched per byte
// - shared interrupt from enabled tx empty, tx done, rx ready/overrun, idle, parity error
// - one bit-time delay after tx enable; enable pulse during a frame sends preamble
// - tx pin released when both enables clear, tx never enabled, or transmitter idle in low power
// - rx enable starts start-bit hunting; clear disables receiver
// - mute while wake-up bit set; hardware clears it on wake sequence
// - break sent while send-break set; set then clear sends one break; the code queues one more break on the clear, after any already sent while set
// - prescaler codes give 1/3/4/13; divisor codes give 2 to the n
// - tx and rx rates are clock over 16 times prescaler times divisor
// - muted receiver sets no status flags and raises no interrupts
// - address mark wake on msb 1: clear mute and set rx ready
module asr_uart #(
   parameter int DATA_W = 8
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // register port
   input wire asr_pkg::asr_bus_s i_bus,
   output logic [DATA_W-1:0] o_rdata,
   // serial line
   input wire logic i_rxd,
   output logic o_txd,
   output logic o_txd_oe,
   // shared interrupt
   output logic o_irq
);
   import asr_pkg::*;

   asr_status_s status;
   logic [7:0] ctrl1;
   logic [7:0] ctrl2;
   logic [7:0] baud;
   logic [7:0] tx_buffer;
   logic [7:0] rx_buffer;
   logic st_seen_rd;
   logic st_seen_wr;
   logic tx_ever;
   logic idle_armed;
   logic wr_data;
   logic rd_data;
   logic clr_rd;
   logic clr_wr;
   logic [7:0] first_prescale_factor;
   logic [14:0] tx_div_cnt;
   logic [14:0] rx_div_cnt;
   logic [14:0] tx_div_max;
   logic [14:0] rx_div_max;
   logic tx_tick;
   logic rx_tick;

   assign wr_data = i_bus.wr && i_bus.addr == `ASR_OFF_DATA;
   assign rd_data = i_bus.rd && i_bus.addr == `ASR_OFF_DATA;
   assign clr_wr = wr_data && st_seen_wr;
   assign clr_rd = rd_data && st_seen_rd;

   // prescaler factor and total divide, 16x oversample tick per stage
   always_comb begin
      unique case (baud[7:6])
         2'h0: first_prescale_factor = 8'h01;
         2'h1: first_prescale_factor = 8'h03;
         2'h2: first_prescale_factor = 8'h04;
         default: first_prescale_factor = 8'h0d;
      endcase
      tx_div_max = 15'((first_prescale_factor << baud[5:3]) - 1);
      rx_div_max = 15'((first_prescale_factor << baud[2:0]) - 1);
   end

   // independent baud dividers, free running; low-power disable gates the sequencers
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_div_cnt <= 15'h0000;
         rx_div_cnt <= 15'h0000;
      end else begin
         tx_div_cnt <= (tx_div_cnt >= tx_div_max) ? 15'h0000 : tx_div_cnt + 15'h0001;
         rx_div_cnt <= (rx_div_cnt >= rx_div_max) ? 15'h0000 : rx_div_cnt + 15'h0001;
      end
   end
   assign tx_tick = tx_div_cnt == 15'h0000;
   assign rx_tick = rx_div_cnt == 15'h0000;

   // transmitter: counts 16 ticks per bit
   asr_tx_e tx_state;
   logic [3:0] tx_sub;
   logic [3:0] tx_bit;
   logic [10:0] tx_shift;
   logic [3:0] tx_len;
   logic tx_kind_data;
   logic tx_move;
   logic te_prev;
   logic preamble_req;
   logic break_req;
   logic sbk_prev;
   logic tx_lpd;
   logic [7:0] tx_word;
   logic tx_par;
   logic tx_msb;

   always_comb begin
      tx_par = ctrl1[`ASR_B_M] ? ^tx_buffer[7:0] : ^tx_buffer[6:0];
      tx_par = tx_par ^ ctrl1[`ASR_B_PS];
      tx_msb = ctrl1[`ASR_B_PCE] ? tx_par : (ctrl1[`ASR_B_M] ? ctrl1[`ASR_B_T8] : tx_buffer[7]);
      tx_word = (ctrl1[`ASR_B_PCE] && !ctrl1[`ASR_B_M]) ? {tx_par, tx_buffer[6:0]} : tx_buffer;
   end
   assign tx_move = tx_state == ASR_TX_IDLE && !status.tx_buf_empty
                    && ctrl2[`ASR_B_TE] && !ctrl1[`ASR_B_LPD];

   // request latches for preamble and break
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         te_prev <= 1'b0;
         sbk_prev <= 1'b0;
         preamble_req <= 1'b0;
         break_req <= 1'b0;
         tx_ever <= 1'b0;
      end else begin
         te_prev <= ctrl2[`ASR_B_TE];
         sbk_prev <= ctrl2[`ASR_B_SBK];
         if (ctrl2[`ASR_B_TE])
            tx_ever <= 1'b1;
         if (ctrl2[`ASR_B_TE] && !te_prev && tx_state != ASR_TX_IDLE)
            preamble_req <= 1'b1;
         // dropped only when the sequencer launches the idle frame or enters ASR_TX_WAIT on a tx enable rise,
         // otherwise a pending word would keep replaying preambles forever
         else if (tx_state == ASR_TX_IDLE && preamble_req && ctrl2[`ASR_B_TE]
                  && (ctrl1[`ASR_B_LPD] || !(ctrl2[`ASR_B_SBK] || break_req)))
            preamble_req <= 1'b0;
         if (sbk_prev && !ctrl2[`ASR_B_SBK])
            break_req <= 1'b1;
         else if (tx_state == ASR_TX_IDLE && break_req)
            break_req <= 1'b0;
      end
   end

   // frame sequencer
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_state <= ASR_TX_IDLE;
         tx_sub <= 4'h0;
         tx_bit <= 4'h0;
         tx_shift <= 11'h7ff;
         tx_len <= 4'h0;
         tx_kind_data <= 1'b0;
         tx_lpd <= 1'b0;
      end else begin
         unique case (tx_state)
            ASR_TX_IDLE: begin
               tx_lpd <= ctrl1[`ASR_B_LPD];
               tx_sub <= 4'h0;
               tx_bit <= 4'h0;
               tx_len <= ctrl1[`ASR_B_M] ? 4'ha : 4'h9;
               if (ctrl2[`ASR_B_TE] && !te_prev) begin
                  tx_state <= ASR_TX_WAIT;
               end else if (ctrl2[`ASR_B_TE] && !ctrl1[`ASR_B_LPD]
                            && (ctrl2[`ASR_B_SBK] || break_req)) begin
                  tx_shift <= 11'h400;
                  tx_kind_data <= 1'b0;
                  tx_state <= ASR_TX_SHIFT;
               end else if (ctrl2[`ASR_B_TE] && preamble_req) begin
                  tx_shift <= 11'h7ff;
                  tx_kind_data <= 1'b0;
                  tx_state <= ASR_TX_SHIFT;
               end else if (tx_move) begin
                  tx_shift <= ctrl1[`ASR_B_M] ? {1'b1, tx_msb, tx_word[7:0], 1'b0}
                                              : {2'b11, tx_word, 1'b0};
                  tx_kind_data <= 1'b1;
                  tx_state <= ASR_TX_SHIFT;
               end
            end
            ASR_TX_WAIT: begin
               if (tx_tick) begin
                  tx_sub <= tx_sub + 4'h1;
                  if (tx_sub == 4'hf)
                     tx_state <= ASR_TX_IDLE;
               end
            end
            ASR_TX_SHIFT: begin
               if (tx_tick) begin
                  tx_sub <= tx_sub + 4'h1;
                  if (tx_sub == 4'hf) begin
                     tx_shift <= {1'b1, tx_shift[10:1]};
                     tx_bit <= tx_bit + 4'h1;
                     if (tx_bit == tx_len)
                        tx_state <= ASR_TX_DONE;
                  end
               end
            end
            ASR_TX_DONE: tx_state <= ASR_TX_IDLE;
         endcase
      end
   end

   // receiver
   asr_rx_e rx_state;
   logic [3:0] rx_sub;
   logic [3:0] rx_bit;
   logic [8:0] rx_shift;
   logic [2:0] rx_vote;
   logic rx_noise;
   logic [3:0] rx_len;
   logic rx_m;
   logic rx_pce;
   logic rx_ps;
   logic [7:0] idle_cnt;
   logic rx_done;
   logic rx_frame_err;
   logic rx_msb;
   logic rx_par_bad;

   always_comb begin
      rx_msb = rx_m ? rx_shift[8] : rx_shift[7];
      rx_par_bad = rx_pce && ((rx_m ? ^rx_shift[8:0] : ^rx_shift[7:0]) != rx_ps);
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_state <= ASR_RX_HUNT;
         rx_sub <= 4'h0;
         rx_bit <= 4'h0;
         rx_shift <= 9'h000;
         rx_vote <= 3'h0;
         rx_noise <= 1'b0;
         rx_len <= 4'h8;
         rx_m <= 1'b0;
         rx_pce <= 1'b0;
         rx_ps <= 1'b0;
         rx_done <= 1'b0;
         rx_frame_err <= 1'b0;
         idle_cnt <= 8'h00;
      end else begin
         rx_done <= 1'b0;
         if (!ctrl2[`ASR_B_RE] || ctrl1[`ASR_B_LPD]) begin
            rx_state <= ASR_RX_HUNT;
            idle_cnt <= 8'h00;
         end else if (rx_tick) begin
            unique case (rx_state)
               ASR_RX_HUNT: begin
                  rx_sub <= 4'h0;
                  rx_bit <= 4'h0;
                  rx_noise <= 1'b0;
                  rx_m <= ctrl1[`ASR_B_M];
                  rx_pce <= ctrl1[`ASR_B_PCE];
                  rx_ps <= ctrl1[`ASR_B_PS];
                  rx_len <= ctrl1[`ASR_B_M] ? 4'h9 : 4'h8;
                  if (!i_rxd) begin
                     rx_state <= ASR_RX_SHIFT;
                     idle_cnt <= 8'h00;
                  end else if (idle_cnt != 8'hff)
                     idle_cnt <= idle_cnt + 8'h01;
               end
               ASR_RX_SHIFT: begin
                  rx_sub <= rx_sub + 4'h1;
                  if (rx_sub >= 4'h7 && rx_sub <= 4'h9)
                     rx_vote <= {rx_vote[1:0], i_rxd};
                  if (rx_sub == 4'hf) begin
                     if (rx_vote != 3'h0 && rx_vote != 3'h7)
                        rx_noise <= 1'b1;
                     if (rx_bit != 4'h0)
                        rx_shift <= {(rx_vote[2] & rx_vote[1]) | (rx_vote[1] & rx_vote[0])
                                     | (rx_vote[2] & rx_vote[0]), rx_shift[8:1]};
                     rx_bit <= rx_bit + 4'h1;
                     if (rx_bit == rx_len)
                        rx_state <= ASR_RX_STOP;
                  end
               end
               ASR_RX_STOP: begin
                  rx_sub <= rx_sub + 4'h1;
                  if (rx_sub == 4'h8) begin
                     rx_frame_err <= !i_rxd;
                     rx_done <= 1'b1;
                     if (!rx_m)
                        rx_shift <= {1'b0, rx_shift[8:1]};
                     rx_state <= ASR_RX_HUNT;
                  end
               end
               default: rx_state <= ASR_RX_HUNT;
            endcase
         end
      end
   end

   // status flags, data buffers and status-access memory
   logic idle_evt;
   logic mute;
   logic wake_addr;
   logic wake_idle;
   assign mute = ctrl2[`ASR_B_RWU];
   assign idle_evt = rx_tick && rx_state == ASR_RX_HUNT && idle_cnt == 8'h9f && i_rxd
                     && ctrl2[`ASR_B_RE];
   assign wake_addr = rx_done && mute && ctrl1[`ASR_B_WAKE] && rx_msb;
   assign wake_idle = idle_evt && mute && !ctrl1[`ASR_B_WAKE];

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status <= asr_status_s'(`ASR_RST_STATUS);
         st_seen_rd <= 1'b0;
         st_seen_wr <= 1'b0;
         idle_armed <= 1'b1;
         tx_buffer <= 8'h00;
         rx_buffer <= 8'h00;
      end else begin
         if (i_bus.rd && i_bus.addr == `ASR_OFF_STATUS) begin
            st_seen_rd <= 1'b1;
            st_seen_wr <= 1'b1;
         end else begin
            if (rd_data)
               st_seen_rd <= 1'b0;
            if (wr_data)
               st_seen_wr <= 1'b0;
         end
         if (wr_data)
            tx_buffer <= i_bus.wdata;
         // clears first; hardware sets below win in the same cycle
         if (clr_wr) begin
            status.tx_buf_empty <= 1'b0;
            status.tx_complete <= 1'b0;
         end
         if (clr_rd) begin
            status.rx_data_ready <= 1'b0;
            status.idle <= 1'b0;
            status.overrun <= 1'b0;
            status.noise_flag <= 1'b0;
            status.framing_error_flag <= 1'b0;
            status.parity_error_flag <= 1'b0;
         end
         if (tx_move)
            status.tx_buf_empty <= 1'b1;
         if (tx_state == ASR_TX_DONE && tx_kind_data)
            status.tx_complete <= 1'b1;
         if (idle_evt && !mute && idle_armed) begin
            status.idle <= 1'b1;
            idle_armed <= 1'b0;
         end
         if (rx_done && (!mute || wake_addr)) begin
            if (status.rx_data_ready && !clr_rd) begin
               status.overrun <= 1'b1;
            end else begin
               rx_buffer <= rx_shift[7:0];
               status.rx_data_ready <= 1'b1;
               idle_armed <= 1'b1;
               if (rx_noise)
                  status.noise_flag <= 1'b1;
               if (rx_frame_err)
                  status.framing_error_flag <= 1'b1;
               if (rx_par_bad)
                  status.parity_error_flag <= 1'b1;
            end
         end
      end
   end

   // control registers; hardware wake-up clears the mute bit
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl1 <= `ASR_RST_CTRL1;
         ctrl2 <= `ASR_RST_CTRL2;
         baud <= `ASR_RST_BAUD;
      end else begin
         if (i_bus.wr && i_bus.addr == `ASR_OFF_CTRL1)
            ctrl1[6:0] <= i_bus.wdata[6:0];
         if (i_bus.wr && i_bus.addr == `ASR_OFF_BAUD)
            baud <= i_bus.wdata;
         if (i_bus.wr && i_bus.addr == `ASR_OFF_CTRL2)
            ctrl2 <= i_bus.wdata;
         else if (wake_addr || wake_idle)
            ctrl2[`ASR_B_RWU] <= 1'b0;
         if (rx_done && rx_m && (!mute || wake_addr) && !status.rx_data_ready)
            ctrl1[`ASR_B_R8] <= rx_shift[8];
      end
   end

   // read data, line outputs and shared interrupt, all registered
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= '0;
         o_txd <= 1'b1;
         o_txd_oe <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_rdata <= '0;
         if (i_bus.rd) begin
            unique case (i_bus.addr)
               `ASR_OFF_STATUS: o_rdata <= DATA_W'(status);
               `ASR_OFF_DATA: o_rdata <= DATA_W'(rx_buffer);
               `ASR_OFF_BAUD: o_rdata <= DATA_W'(baud);
               `ASR_OFF_CTRL1: o_rdata <= DATA_W'(ctrl1);
               `ASR_OFF_CTRL2: o_rdata <= DATA_W'(ctrl2);
               default: o_rdata <= '0;
            endcase
         end
         o_txd <= (tx_state == ASR_TX_SHIFT) ? tx_shift[0] : 1'b1;
         o_txd_oe <= tx_ever && (ctrl2[`ASR_B_TE] || ctrl2[`ASR_B_RE])
                     && !(tx_lpd && tx_state == ASR_TX_IDLE);
         o_irq <= (ctrl2[`ASR_B_TIE] && status.tx_buf_empty)
                  || (ctrl2[`ASR_B_TX_DONE_IRQ_ENABLE] && status.tx_complete)
                  || (!mute && ctrl2[`ASR_B_RIE] && (status.rx_data_ready || status.overrun))
                  || (!mute && ctrl2[`ASR_B_IDLE_IRQ_ENABLE] && status.idle)
                  || (!mute && ctrl1[`ASR_B_PIE] && status.parity_error_flag);
      end
   end
endmodule
